// [hw/pss_pin_sync.sv]
// three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/10ps
module pss_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } pss_sync_state_t;

   pss_sync_state_t st_reg;
   pss_sync_state_t st_next;

   always_comb begin
      st_next     = st_reg;
      st_next.s1  = pinIn;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      st_next.out = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3))
                  | (st_reg.out & (st_reg.s2 ^ st_reg.s3));
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pinOut = st_reg.out;
endmodule

// [hw/pss_pkg.sv]
// constants, register map and types shared by the supply selector files
package pss_pkg;
   localparam int CLK_PERIOD_NS   = 40;
   localparam int TICK_PERIOD_NS  = 1000;
   localparam int TICK_CYCLES     = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_FILTER_US = 8;
   localparam int FILTER_TICKS    = (FAULT_FILTER_US * 1000 + TICK_PERIOD_NS - 1)
                                    / TICK_PERIOD_NS;
   localparam int QUAL_TIME_MS    = 256;
   localparam int QUAL_TICKS      = QUAL_TIME_MS * 1000000 / TICK_PERIOD_NS;
   localparam int SOFT_TIME_MS    = 32;
   localparam int SOFT_TICKS      = SOFT_TIME_MS * 1000000 / TICK_PERIOD_NS;
   localparam int NUM_CH          = 3;

   // register map, byte addresses
   localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
   localparam int CTRL_EN_BIT     = 0;
   localparam int ST_VALID_LSB    = 0;
   localparam int ST_GATE_LSB     = 3;
   localparam int ST_SEL_LSB      = 6;
   localparam int ST_SOFT_BIT     = 8;
   localparam int ST_ARMED_BIT    = 9;
   localparam int ST_CAS_BIT      = 10;
   localparam int ST_GOFF_LSB     = 11;
   localparam int ST_REV_LSB      = 14;

   // packing of the synchronised pin vector
   localparam int SYN_OVA  = 0;
   localparam int SYN_OVB  = 3;
   localparam int SYN_UVB  = 6;
   localparam int SYN_UVA  = 9;
   localparam int SYN_GOFF = 12;
   localparam int SYN_REV  = 15;
   localparam int SYN_RAIL = 18;
   localparam int SYN_EN   = 19;
   localparam int SYN_SHUTDOWN_N = 20;
   localparam int SYN_W    = 21;

   typedef enum logic [1:0] {SW_OFF, SW_MAKE, SW_ON, SW_BREAK} pss_sw_state_t;
   typedef enum logic [1:0] {RS_NONE, RS_CTRL, RS_STATUS} pss_reg_sel_t;
endpackage

// [hw/pss_qual_timer.sv]
// per-channel window fault latches, fault filter and qualification timer
`timescale 1ns/10ps
module pss_qual_timer #(
   parameter int QUAL_TICKS   = pss_pkg::QUAL_TICKS,
   parameter int FILTER_TICKS = pss_pkg::FILTER_TICKS
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic tick,
   input  wire logic evalEn,
   input  wire logic ovAboveThr,
   input  wire logic ovBelowHys,
   input  wire logic uvBelowThr,
   input  wire logic uvAboveHys,
   output logic      qualified,
   output logic      channelGoodN
);
   localparam int QW = $clog2(QUAL_TICKS + 1);
   localparam int FW = $clog2(FILTER_TICKS + 1);

   typedef struct packed {
      logic          ovFault;
      logic          uvFault;
      logic [FW-1:0] filtCnt;
      logic [QW-1:0] qualCnt;
      logic          qualified;
      logic          goodN;
   } pss_qual_state_t;

   pss_qual_state_t st_reg;
   pss_qual_state_t st_next;
   logic            outside;

   always_comb begin
      st_next = st_reg;
      outside = 1'b0;
      if (!evalEn) begin
         // shutdown: evaluation off, timer and flag cleared
         st_next       = '0;
         st_next.goodN = 1'b1;
      end else begin
         // faults leave only past the hysteresis point
         if (ovAboveThr) begin
            st_next.ovFault = 1'b1;
         end else if (ovBelowHys) begin
            st_next.ovFault = 1'b0;
         end
         if (uvBelowThr) begin
            st_next.uvFault = 1'b1;
         end else if (uvAboveHys) begin
            st_next.uvFault = 1'b0;
         end
         outside = st_next.ovFault | st_next.uvFault;
         if (outside) begin
            st_next.qualCnt = '0;
            if (tick) begin
               if (st_reg.filtCnt == FW'(FILTER_TICKS)) begin
                  st_next.qualified = 1'b0;
               end else begin
                  st_next.filtCnt = st_reg.filtCnt + FW'(1);
               end
            end
         end else begin
            st_next.filtCnt = '0;
            if (tick && !st_reg.qualified) begin
               if (st_reg.qualCnt == QW'(QUAL_TICKS)) begin
                  st_next.qualified = 1'b1;
               end else begin
                  st_next.qualCnt = st_reg.qualCnt + QW'(1);
               end
            end
         end
         // flag drops out at once, selection waits for the filter
         st_next.goodN = ~(st_next.qualified & ~outside);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.goodN <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign qualified    = st_reg.qualified;
   assign channelGoodN = st_reg.goodN;
endmodule

// [hw/pss_selector.sv]
// prioritised three-input supply selector with AHB-Lite control and status
//
// Functional notes
// - channel one highest, three lowest, fixed
// - valid after 256 ms inside window; connect best
// - valid flag low while channel qualified and inside window
// - connected channel out 8 us: switch to next
// - higher channel valid: drop lower, then connect
// - connect only after latched gate-off of previous
// - turn on only after latched reverse-block indication
// - soft-start first connect; ends on disconnect or 32 ms
// - re-arm soft-start on shutdown release or low rail
// - enable low: all off, timers kept running
// - window evaluation and flags continue while disabled
// - shutdown: all off, evaluation stops, timers clear
// - faults clear only past hysteresis point
// - valid flag released as soon as window left
// - cascade low when valid and enabled, or disabled
// - cascade high when idle and off, or shutdown
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module pss_selector #(
   parameter int QUAL_TICKS = pss_pkg::QUAL_TICKS,
   parameter int SOFT_TICKS = pss_pkg::SOFT_TICKS
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [2:0]  ovAboveThr,
   input  wire logic [2:0]  ovBelowHys,
   input  wire logic [2:0]  uvBelowThr,
   input  wire logic [2:0]  uvAboveHys,
   input  wire logic [2:0]  gateOffDetect,
   input  wire logic [2:0]  reverseBlockDetect,
   input  wire logic        outputRailLow,
   input  wire logic        enableIn,
   input  wire logic        shutdownN,
   output logic      [2:0]  switchGateDrive,
   output logic             softRampActive,
   output logic      [2:0]  channelGoodN,
   output logic             cascadeOut
);
   localparam int SW = $clog2(SOFT_TICKS + 1);
   localparam int TW = $clog2(pss_pkg::TICK_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(pss_pkg::TICK_CYCLES - 1);

   typedef struct packed {
      pss_pkg::pss_sw_state_t  st;
      logic [1:0]              sel;
      logic [2:0]              gateOn;
      logic [2:0]              gateOffLatch;
      logic [2:0]              revLatch;
      logic                    softArmed;
      logic                    softActive;
      logic [SW-1:0]           softCnt;
      logic                    shdnPrev;
      logic                    cascade;
      logic                    swEnable;
      logic                    busPend;
      logic                    busWrite;
      pss_pkg::pss_reg_sel_t   busSel;
      logic [31:0]             rdata;
      logic [TW-1:0]           tickCnt;
      logic                    tick;
   } pss_sel_state_t;

   pss_sel_state_t st_reg;
   pss_sel_state_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation and per-channel qualification

   logic [pss_pkg::SYN_W-1:0] pinSync;
   logic [2:0]                selOk;
   logic [2:0]                goodN;
   logic                      shdnSync;
   logic                      enSync;
   logic                      railLowSync;
   logic [2:0]                gateOffSync;
   logic [2:0]                revSync;

   pss_pin_sync #(
      .W (pss_pkg::SYN_W)
   ) u_sync (
      .mclk   (mclk),
      .rst    (rst),
      .pinIn  ({shutdownN, enableIn, outputRailLow, reverseBlockDetect, gateOffDetect,
                uvAboveHys, uvBelowThr, ovBelowHys, ovAboveThr}),
      .pinOut (pinSync)
   );

   assign shdnSync    = pinSync[pss_pkg::SYN_SHUTDOWN_N];
   assign enSync      = pinSync[pss_pkg::SYN_EN];
   assign railLowSync = pinSync[pss_pkg::SYN_RAIL];
   assign gateOffSync = pinSync[pss_pkg::SYN_GOFF +: 3];
   assign revSync     = pinSync[pss_pkg::SYN_REV +: 3];

   // timers see shutdown only, never enable, so disabling keeps them going
   generate
      for (genvar i = 0; i < pss_pkg::NUM_CH; i++) begin : g_ch
         pss_qual_timer #(
            .QUAL_TICKS   (QUAL_TICKS),
            .FILTER_TICKS (pss_pkg::FILTER_TICKS)
         ) u_qual (
            .mclk         (mclk),
            .rst          (rst),
            .tick         (st_reg.tick),
            .evalEn       (shdnSync),
            .ovAboveThr   (pinSync[pss_pkg::SYN_OVA + i]),
            .ovBelowHys   (pinSync[pss_pkg::SYN_OVB + i]),
            .uvBelowThr   (pinSync[pss_pkg::SYN_UVB + i]),
            .uvAboveHys   (pinSync[pss_pkg::SYN_UVA + i]),
            .qualified    (selOk[i]),
            .channelGoodN (goodN[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic pss_pkg::pss_reg_sel_t regSel(input logic [31:0] addr);
      pss_pkg::pss_reg_sel_t r;
      r = pss_pkg::RS_NONE;
      if (addr == pss_pkg::CTRL_OFFSET) begin
         r = pss_pkg::RS_CTRL;
      end else if (addr == pss_pkg::STATUS_OFFSET) begin
         r = pss_pkg::RS_STATUS;
      end
      return r;
   endfunction

   // fixed position order, never voltage
   function automatic logic [2:0] pickFirst(input logic [2:0] v);
      logic [2:0] r;
      r = 3'h0;
      if (v[0]) begin
         r = {1'b1, 2'h0};
      end else if (v[1]) begin
         r = {1'b1, 2'h1};
      end else if (v[2]) begin
         r = {1'b1, 2'h2};
      end
      return r;
   endfunction

   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[pss_pkg::ST_VALID_LSB +: 3] = ~goodN;
      statusWord[pss_pkg::ST_GATE_LSB +: 3]  = st_reg.gateOn;
      statusWord[pss_pkg::ST_SEL_LSB +: 2]   = st_reg.sel;
      statusWord[pss_pkg::ST_SOFT_BIT]       = st_reg.softActive;
      statusWord[pss_pkg::ST_ARMED_BIT]      = st_reg.softArmed;
      statusWord[pss_pkg::ST_CAS_BIT]        = st_reg.cascade;
      statusWord[pss_pkg::ST_GOFF_LSB +: 3]  = st_reg.gateOffLatch;
      statusWord[pss_pkg::ST_REV_LSB +: 3]   = st_reg.revLatch;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   logic       run;
   logic [2:0] tgt;
   logic       tgtMatch;
   logic       accept;

   always_comb begin
      st_next  = st_reg;
      run      = shdnSync & enSync & st_reg.swEnable;
      tgt      = pickFirst(selOk);
      tgtMatch = tgt[2] && (tgt[1:0] == st_reg.sel);
      accept   = hsel & htrans[1] & hready & (hsize == 3'h2);

      // 1 us timebase
      st_next.tick    = (st_reg.tickCnt == TICK_LAST);
      st_next.tickCnt = st_next.tick ? '0 : st_reg.tickCnt + TW'(1);

      // soft-start window runs out
      if (st_reg.softActive && st_reg.tick) begin
         if (st_reg.softCnt == SW'(SOFT_TICKS - 1)) begin
            st_next.softActive = 1'b0;
         end else begin
            st_next.softCnt = st_reg.softCnt + SW'(1);
         end
      end

      unique case (st_reg.st)
         pss_pkg::SW_OFF: begin
            if (run && tgt[2]) begin
               st_next.sel = tgt[1:0];
               st_next.st  = pss_pkg::SW_MAKE;
            end
         end
         pss_pkg::SW_MAKE: begin
            if (!run || !tgtMatch) begin
               st_next.st = pss_pkg::SW_OFF;
            end else if (st_reg.revLatch[st_reg.sel]) begin
               st_next.gateOn[st_reg.sel] = 1'b1;
               st_next.st = pss_pkg::SW_ON;
               if (st_reg.softArmed) begin
                  st_next.softArmed  = 1'b0;
                  st_next.softActive = 1'b1;
                  st_next.softCnt    = '0;
               end
            end
         end
         pss_pkg::SW_ON: begin
            // lost, disabled or outranked: break first
            if (!run || !tgtMatch) begin
               st_next.gateOn     = 3'h0;
               st_next.softActive = 1'b0;
               st_next.st         = pss_pkg::SW_BREAK;
            end
         end
         pss_pkg::SW_BREAK: begin
            if (st_reg.gateOffLatch[st_reg.sel]) begin
               st_next.st = pss_pkg::SW_OFF;
            end
         end
      endcase

      // re-arm after consumption so a simultaneous request is kept;
      // rail-low counts only with all gates off, its synced level lags turn-on
      st_next.shdnPrev = shdnSync;
      if ((shdnSync && !st_reg.shdnPrev)
          || (railLowSync && st_reg.gateOn == 3'h0 && st_next.gateOn == 3'h0)) begin
         st_next.softArmed = 1'b1;
      end

      for (int i = 0; i < pss_pkg::NUM_CH; i++) begin
         // set only while held off, cleared by turn-on
         if (gateOffSync[i] && !st_reg.gateOn[i] && !st_next.gateOn[i]) begin
            st_next.gateOffLatch[i] = 1'b1;
         end else if (st_next.gateOn[i] && !st_reg.gateOn[i]) begin
            st_next.gateOffLatch[i] = 1'b0;
         end
         // held for the connecting channel, dropped once it is off
         if (revSync[i] && st_reg.st == pss_pkg::SW_MAKE && st_reg.sel == 2'(i)) begin
            st_next.revLatch[i] = 1'b1;
         end else if (!st_next.gateOn[i]
                      && !(st_next.st == pss_pkg::SW_MAKE && st_next.sel == 2'(i))) begin
            st_next.revLatch[i] = 1'b0;
         end
      end

      // cascade: otherwise holds its last level
      if (!shdnSync) begin
         st_next.cascade = 1'b1;
      end else if (!enSync || (|selOk)) begin
         st_next.cascade = 1'b0;
      end else if (st_reg.gateOn == 3'h0 && (&st_reg.gateOffLatch)) begin
         st_next.cascade = 1'b1;
      end

      // bus: zero wait states, read data latched in address phase
      if (st_reg.busPend && st_reg.busWrite && st_reg.busSel == pss_pkg::RS_CTRL) begin
         st_next.swEnable = hwdata[pss_pkg::CTRL_EN_BIT];
      end
      st_next.busPend = accept;
      if (accept) begin
         st_next.busWrite = hwrite;
         st_next.busSel   = regSel(haddr);
         if (!hwrite) begin
            unique case (regSel(haddr))
               pss_pkg::RS_CTRL:   st_next.rdata = {31'h0000_0000, st_reg.swEnable};
               pss_pkg::RS_STATUS: st_next.rdata = statusWord;
               default:            st_next.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg           <= '0;
         st_reg.st        <= pss_pkg::SW_OFF;
         st_reg.softArmed <= 1'b1;
         st_reg.cascade   <= 1'b1;
         st_reg.swEnable  <= pss_pkg::CTRL_RESET[pss_pkg::CTRL_EN_BIT];
         st_reg.busSel    <= pss_pkg::RS_NONE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = st_reg.rdata;
   assign switchGateDrive = st_reg.gateOn;
   assign softRampActive  = st_reg.softActive;
   assign channelGoodN    = goodN;
   assign cascadeOut      = st_reg.cascade;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_ONE_GATE: assert property ($onehot0(st_reg.gateOn))
      else $error("more than one channel gate on");

   AST_BREAK_FIRST: assert property (
      (|(st_reg.gateOn & ~$past(st_reg.gateOn))) |-> ($past(st_reg.gateOn) == 3'h0))
      else $error("gate turned on before previous gate off");

   AST_REV_HOLD: assert property (
      (|(st_reg.gateOn & ~$past(st_reg.gateOn)))
      |-> (|($past(st_reg.revLatch) & st_reg.gateOn)))
      else $error("gate turned on without reverse-block latch");

   AST_SHUTDOWN_N_OFF: assert property (!shdnSync |-> ##1 (st_reg.gateOn == 3'h0))
      else $error("gates not off one cycle after shutdown");

   AST_EN_OFF: assert property (!enSync |-> ##1 (st_reg.gateOn == 3'h0))
      else $error("gates not off one cycle after enable low");

   AST_SHUTDOWN_N_FLAGS: assert property (!shdnSync |-> ##2 (channelGoodN == 3'h7))
      else $error("valid flags not released in shutdown");

   AST_PRIORITY: assert property (
      (st_reg.st == pss_pkg::SW_ON && run && selOk[0] && st_reg.sel != 2'h0)
      |-> ##1 (st_reg.st == pss_pkg::SW_BREAK && st_reg.gateOn == 3'h0))
      else $error("lower channel kept on while channel one valid");

   AST_SOFT_END: assert property (
      (st_reg.softActive && st_reg.tick && st_reg.softCnt == SW'(SOFT_TICKS - 1))
      |=> !st_reg.softActive)
      else $error("soft-start window overran");

   AST_REARM: assert property ($rose(shdnSync) |=> st_reg.softArmed)
      else $error("soft-start not re-armed after shutdown release");

   AST_CAS_SHUTDOWN_N: assert property (!shdnSync |=> st_reg.cascade)
      else $error("cascade not high in shutdown");

   AST_CAS_EN: assert property ((shdnSync && !enSync) |=> !st_reg.cascade)
      else $error("cascade not low with enable low");
endmodule

// [sim/pss_selector_tb.sv]
// self-checking bench for the prioritised supply selector
`timescale 1ns/10ps
module pss_selector_tb;
   localparam int QT = 50;
   localparam int ST = 100;
   localparam int QCYC = (QT + 1) * 25;
   logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic enableIn, shutdownN, softRampActive, cascadeOut, railLow;
   logic [1:0] htrans;
   logic [2:0] hsize, switchGateDrive, channelGoodN, ovA, ovB, uvB, uvA, gOff, rBlk;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [8:0] supState;
   logic [7:0] respDelay;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   assign hready = hreadyout;
   pss_selector #(.QUAL_TICKS(QT), .SOFT_TICKS(ST)) i_pss_selector (
      .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ovAboveThr(ovA),
      .ovBelowHys(ovB), .uvBelowThr(uvB), .uvAboveHys(uvA), .gateOffDetect(gOff),
      .reverseBlockDetect(rBlk), .outputRailLow(railLow), .enableIn(enableIn),
      .shutdownN(shutdownN), .switchGateDrive(switchGateDrive),
      .softRampActive(softRampActive), .channelGoodN(channelGoodN),
      .cascadeOut(cascadeOut));
   pss_supply_model i_pss_supply_model (
      .mclk(mclk), .supState(supState), .respDelay(respDelay), .gateOn(switchGateDrive),
      .ovAbove(ovA), .ovBelowHys(ovB), .uvBelow(uvB), .uvAboveHys(uvA),
      .gateOff(gOff), .revBlock(rBlk), .railLow(railLow));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [2:0] pick(input int k);
      case (k)
         0: return switchGateDrive;
         1: return channelGoodN;
         default: return {2'b00, cascadeOut};
      endcase
   endfunction
   // sampled on the falling edge, after the rising edge updates have landed
   task automatic waitFor(input int k, input logic [2:0] exp, input int lim, input string w);
      int n;
      n = 0;
      @(negedge mclk);
      while (pick(k) !== exp && n < lim) begin
         @(negedge mclk);
         n++;
      end
      chk({29'h0, pick(k)}, {29'h0, exp}, w);
   endtask
   task automatic holdFor(input int k, input logic [2:0] exp, input int lim, input string w);
      logic bad;
      bad = 1'b0;
      repeat (lim) begin
         @(negedge mclk);
         if (pick(k) !== exp) bad = 1'b1;
      end
      chk({31'h0, bad}, 32'h0, w);
   endtask
   task automatic setSup(input int ch, input logic [2:0] st);
      @(posedge mclk);
      supState[3*ch +: 3] <= st;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
      hsel <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic tReset;
      repeat (10) @(negedge mclk);
      chk(channelGoodN, 3'b111, "flags after reset");
      chk(switchGateDrive, 3'b000, "gates after reset");
      chk(cascadeOut, 1'b1, "cascade idle");
      ahb(1'b0, pss_pkg::CTRL_OFFSET, 32'h0);
      chk(q, pss_pkg::CTRL_RESET, "ctrl reset value");
      chk(hresp, 1'b0, "okay response");
      ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
      hsize <= 3'b000;
      ahb(1'b1, pss_pkg::CTRL_OFFSET, 32'h0000_0000);
      hsize <= 3'b010;
      ahb(1'b0, 32'h0000_0010, 32'h0);
      chk(q, 32'h0000_0000, "unmapped read");
      ahb(1'b0, pss_pkg::CTRL_OFFSET, 32'h0);
      chk(q, pss_pkg::CTRL_RESET, "ctrl untouched");
   endtask
   task automatic tQualify;
      setSup(1, 3'h0);
      setSup(2, 3'h0);
      holdFor(1, 3'b111, QCYC - 100, "valid too early");
      waitFor(1, 3'b001, 200, "ch2 ch3 valid");
      waitFor(0, 3'b010, 50, "ch2 wins over ch3");
      @(negedge mclk);
      chk(softRampActive, 1'b1, "first connect ramps");
      chk(cascadeOut, 1'b0, "cascade low when valid");
      ahb(1'b0, pss_pkg::STATUS_OFFSET, 32'h0);
      chk(q & 32'h0000_00ff, 32'h0000_0056, "status valid gate select");
   endtask
   task automatic tPriority;
      respDelay <= 8'd40;
      setSup(0, 3'h0);
      waitFor(1, 3'b000, QCYC + 200, "ch1 valid");
      waitFor(0, 3'b000, 20, "lower dropped first");
      chk(softRampActive, 1'b0, "ramp ends on disconnect");
      holdFor(0, 3'b000, 30, "waits for gate off");
      waitFor(0, 3'b001, 80, "ch1 connected");
      chk(softRampActive, 1'b0, "only first connect ramps");
      respDelay <= 8'd2;
   endtask
   task automatic tFault;
      setSup(0, 3'h1);
      waitFor(1, 3'b001, 10, "flag released at once");
      holdFor(0, 3'b001, 150, "filter keeps gate");
      waitFor(0, 3'b010, 150, "next channel after filter");
      setSup(0, 3'h2);
      holdFor(1, 3'b001, QCYC + 200, "no recovery inside band");
      setSup(0, 3'h0);
      holdFor(1, 3'b001, QCYC / 2, "requalifying");
      setSup(0, 3'h1);
      repeat (10) @(posedge mclk);
      setSup(0, 3'h0);
      holdFor(1, 3'b001, QCYC - 150, "count restarted");
      waitFor(1, 3'b000, 300, "ch1 valid again");
      waitFor(0, 3'b001, 80, "back to ch1");
   endtask
   task automatic tEnable;
      @(posedge mclk) enableIn <= 1'b0;
      waitFor(0, 3'b000, 10, "off when disabled");
      chk(cascadeOut, 1'b0, "cascade low when disabled");
      setSup(2, 3'h3);
      waitFor(1, 3'b100, 10, "flags while disabled");
      setSup(2, 3'h4);
      @(posedge mclk) enableIn <= 1'b1;
      waitFor(0, 3'b001, 40, "timers kept");
      ahb(1'b1, pss_pkg::CTRL_OFFSET, 32'h0000_0000);
      waitFor(0, 3'b000, 10, "software disable");
      ahb(1'b1, pss_pkg::CTRL_OFFSET, 32'h0000_0001);
      waitFor(0, 3'b001, 40, "software enable");
      holdFor(1, 3'b100, QCYC + 200, "under band stays invalid");
      setSup(2, 3'h3);
   endtask
   task automatic tShutdown;
      @(posedge mclk) shutdownN <= 1'b0;
      waitFor(0, 3'b000, 10, "off in shutdown");
      waitFor(1, 3'b111, 10, "flags cleared");
      waitFor(2, 3'b001, 10, "cascade high in shutdown");
      @(posedge mclk) shutdownN <= 1'b1;
      holdFor(1, 3'b111, QCYC - 100, "timers cleared");
      waitFor(1, 3'b100, 300, "requalified");
      waitFor(0, 3'b001, 40, "connect after shutdown");
      @(negedge mclk);
      chk(softRampActive, 1'b1, "ramp re-armed");
      repeat (ST * 25 + 100) @(negedge mclk);
      chk(softRampActive, 1'b0, "ramp window expired");
      setSup(0, 3'h3);
      setSup(1, 3'h3);
      waitFor(0, 3'b000, 400, "all off");
      waitFor(2, 3'b001, 100, "cascade high when idle");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // break-before-make: never two gates on at once
   always @(negedge mclk) begin
      if (!rst && (switchGateDrive & (switchGateDrive - 3'd1)) !== 3'b000) begin
         chk({29'h0, switchGateDrive}, 32'h0, "gate overlap");
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      enableIn = 1'b1;
      shutdownN = 1'b1;
      supState = {3{3'h3}};
      respDelay = 8'd2;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      tReset;
      tQualify;
      tPriority;
      tFault;
      tEnable;
      tShutdown;
      end_of_test;
   end
endmodule

// [sim/pss_supply_model.sv]
// behavioural switches and input supplies facing the supply selector
`timescale 1ns/10ps
module pss_supply_model (
   input  wire logic       mclk,
   input  wire logic [8:0] supState,
   input  wire logic [7:0] respDelay,
   input  wire logic [2:0] gateOn,
   output logic      [2:0] ovAbove,
   output logic      [2:0] ovBelowHys,
   output logic      [2:0] uvBelow,
   output logic      [2:0] uvAboveHys,
   output logic      [2:0] gateOff,
   output logic      [2:0] revBlock,
   output logic            railLow
);
   // per channel: 0 in window, 1 over, 2 over band, 3 under, 4 under band
   logic [7:0] offCnt [3] = '{default: 8'h00};
   logic [7:0] idleCnt = 8'h00;
   always @(posedge mclk) begin
      for (int i = 0; i < 3; i++) begin
         offCnt[i] <= gateOn[i] ? 8'h00 : offCnt[i] + {7'h00, offCnt[i] != 8'hff};
      end
      idleCnt <= |gateOn ? 8'h00 : idleCnt + {7'h00, idleCnt != 8'hff};
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ovAbove[i] = supState[3*i +: 3] == 3'h1;
         ovBelowHys[i] = supState[3*i +: 3] > 3'h2 || supState[3*i +: 3] == 3'h0;
         uvBelow[i] = supState[3*i +: 3] == 3'h3;
         uvAboveHys[i] = supState[3*i +: 3] < 3'h3;
         // gate-off and reverse-block take respDelay cycles to settle, rail-low 255 idle cycles; slow switches stretch it
         gateOff[i] = offCnt[i] >= respDelay;
         revBlock[i] = idleCnt >= respDelay;
      end
      railLow = idleCnt == 8'hff;
   end
endmodule
